// [core/tcc_core.sv]
// Four-channel capture/compare logic behind an APB register slave.
// Assumes counter value, tick and overflow pulses come from the counter
// block, all synchronous to pclk; channel pins are sampled directly.
`timescale 1ns/100ps
`default_nettype none

// Contract
// (R01) Software stops and resets the counter before changing mode bits.
// (R02) In capture mode the select bits pick the active pin edges.
// (R03) In compare mode the select bits pick the pin action on match.
// (R04) Select bits both zero: channel leaves pin to port control.
// (R05) Reset clears both select bits of every channel.
// (R06) Select bits zero: unbuffered bit sets initial level, 0 high, 1 low.
// (R07) Capture codes: 01 rising, 10 falling, 11 either edge.
// (R08) Compare codes, buffered or not: 01 toggle, 10 clear, 11 set.
// (R09) External driver holds pin stable two clocks before capture enable.
// (R10) Compare channel with toggle-on-overflow inverts pin on overflow.
// (R11) Reset clears every toggle-on-overflow bit.
// (R12) Overflow toggle wins over a simultaneous compare match.
// (R13) With toggle-on-overflow clear, max-duty forces 100% duty.
// (R14) Max-duty changes take effect from the next period.
// (R15) Value register holds captured count or compare value.
// (R16) Capture mode: high byte read blocks captures until low read.
// (R17) Compare modes: high byte write blocks matches until low write.
// (R18) Flag sets on active edge or on count equal to value.
// (R19) Flag clears by read-with-flag then write zero; event wins.
// (R20) Buffered bit on channel 0/2 disables the paired odd channel.
// (R21) Counter overflow marks the period boundary.
// (R22) Buffered pair values alternate; new value used from next period.
// (R23) Channel interrupt request is flag and enable together.
module tcc_core
   import tcc_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [VW-1:0]       cnt_value,
   input  wire logic                cnt_tick,
   input  wire logic                cnt_ovf,
   input  wire logic [NCH-1:0]      ch_pin_in,
   output logic      [NCH-1:0]      ch_pin_out,
   output logic      [NCH-1:0]      ch_pin_oe,
   output logic      [NCH-1:0]      ch_irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [6:0]     ctrl_r   [NCH];
   logic [6:0]     ctrl_nxt [NCH];
   logic [VW-1:0]  val_r    [NCH];
   logic [VW-1:0]  val_nxt  [NCH];
   logic [NCH-1:0] flag_r, flag_nxt;
   logic [NCH-1:0] arm_r, arm_nxt;
   logic [NCH-1:0] rblk_r, rblk_nxt;
   logic [NCH-1:0] wblk_r, wblk_nxt;
   logic [NCH-1:0] out_r, out_nxt;
   logic [NCH-1:0] oe_r, oe_nxt;
   logic [NCH-1:0] pin_q_r, pin_q_nxt;
   logic [NCH-1:0] maxe_r, maxe_nxt;
   logic [NCH-1:0] irq_r, irq_nxt;
   logic [1:0]     act_odd_r, act_odd_nxt;
   logic [1:0]     last_odd_r, last_odd_nxt;
   logic           pready_r, pready_nxt;
   logic           pslverr_r, pslverr_nxt;
   logic [31:0]    prdata_r, prdata_nxt;

   // ------------------------------------------------------------
   // Decode and per-channel events
   // ------------------------------------------------------------
   logic           acc, wr, rd, mapped;
   logic [3:0]     rgn;
   logic [1:0]     idx;
   tcc_mode_t      mode   [NCH];
   logic [NCH-1:0] dis, ev_cap, match, full_lvl, sel;
   logic [VW-1:0]  cmp    [NCH];

   assign acc = psel & penable & pready_r;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;
   assign rgn = paddr[7:4];
   assign idx = paddr[3:2];

   always_comb begin
      mapped = (rgn == RGN_CTRL) || (rgn == RGN_VALH) ||
               (rgn == RGN_VALL) || (paddr[7:2] == ADDR_STAT[7:2]);
      for (int c = 0; c < NCH; c++) begin
         sel[c] = (idx == c[1:0]);
         // Odd channel is swallowed by its buffered even partner
         dis[c] = (c % 2 == 1) ? ctrl_r[c & 2][B_BUF] : 1'b0; // see (R20)
         mode[c] = tcc_mode(ctrl_r[c], dis[c]);
         // Buffered even channel compares against the active pair member
         if (mode[c] == TCC_BUFFERED && act_odd_r[c/2]) begin // see (R22)
            cmp[c] = val_r[c | 1];
         end else begin
            cmp[c] = val_r[c];
         end
         ev_cap[c] = (mode[c] == TCC_CAPTURE) && !rblk_r[c] &&   // see (R16)
                     ((ctrl_r[c][B_ELL] && ch_pin_in[c] && !pin_q_r[c]) ||
                      (ctrl_r[c][B_ELH] && !ch_pin_in[c] && pin_q_r[c]));
         // see (R02) (R07) above; see (R17) (R18) below
         match[c] = (mode[c] == TCC_COMPARE || mode[c] == TCC_BUFFERED) &&
                    cnt_tick && (cnt_value == cmp[c]) && !wblk_r[c] &&
                    !((mode[c] == TCC_BUFFERED) && wblk_r[c|1]);
         // Full-duty level is low for set-on-compare and high for clear or toggle
         full_lvl[c] = (ctrl_r[c][B_ELH:B_ELL] != ELS_SET);
      end
   end

   // ------------------------------------------------------------
   // Channel next state
   // ------------------------------------------------------------
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         ctrl_nxt[c]  = ctrl_r[c];
         val_nxt[c]   = val_r[c];
         flag_nxt[c]  = flag_r[c];
         arm_nxt[c]   = arm_r[c];
         rblk_nxt[c]  = rblk_r[c];
         wblk_nxt[c]  = wblk_r[c];
         out_nxt[c]   = out_r[c];
         pin_q_nxt[c] = ch_pin_in[c];
         // Period boundary latch keeps a partly run period intact
         maxe_nxt[c]  = cnt_ovf ? ctrl_r[c][B_MAX] : maxe_r[c]; // see (R14) (R21)
         oe_nxt[c]    = (mode[c] == TCC_COMPARE) ||
                        (mode[c] == TCC_BUFFERED);   // see (R04) (R20)

         // Control register writes; buffered bit only exists on even ones
         if (wr && rgn == RGN_CTRL && sel[c] && !dis[c]) begin
            ctrl_nxt[c] = pwdata[6:0];
            if (c % 2 == 1) begin
               ctrl_nxt[c][B_BUF] = 1'b0;   // see (R20)
            end
         end

         // Flag: read-with-flag arms, write of zero clears; set wins
         if (rd && rgn == RGN_CTRL && sel[c] && flag_r[c]) begin
            arm_nxt[c] = 1'b1;
         end else if (wr && rgn == RGN_CTRL && sel[c]) begin
            arm_nxt[c] = 1'b0;
         end
         if (wr && rgn == RGN_CTRL && sel[c] && !dis[c] && arm_r[c] &&
             !pwdata[B_FLAG]) begin
            flag_nxt[c] = 1'b0;   // see (R19)
         end
         if (ev_cap[c] || match[c]) begin
            flag_nxt[c] = 1'b1;   // see (R18) (R19)
         end

         // Value bytes and their coherency locks
         if (wr && rgn == RGN_VALH && sel[c]) begin
            val_nxt[c][VW-1:BW] = pwdata[BW-1:0];
            if (ctrl_r[c][B_BUF] || ctrl_r[c][B_UNB]) begin
               wblk_nxt[c] = 1'b1;   // see (R17)
            end
         end
         if (wr && rgn == RGN_VALL && sel[c]) begin
            val_nxt[c][BW-1:0] = pwdata[BW-1:0];
            wblk_nxt[c] = 1'b0;   // see (R17)
         end
         if (rd && rgn == RGN_VALH && sel[c] &&
             !ctrl_r[c][B_BUF] && !ctrl_r[c][B_UNB]) begin
            rblk_nxt[c] = 1'b1;   // see (R16)
         end
         if (rd && rgn == RGN_VALL && sel[c]) begin
            rblk_nxt[c] = 1'b0;   // see (R16)
         end
         if (ev_cap[c]) begin
            val_nxt[c] = cnt_value;   // see (R15)
         end

         // Pin level; the port owns the pin while disconnected
         unique case (mode[c])
            TCC_PORT: begin
               out_nxt[c] = ~ctrl_r[c][B_UNB];   // see (R06)
            end
            TCC_COMPARE, TCC_BUFFERED: begin
               if (maxe_r[c] && !ctrl_r[c][B_TOV]) begin
                  out_nxt[c] = full_lvl[c];   // see (R13)
               end else if (ctrl_r[c][B_TOV] && cnt_ovf) begin
                  out_nxt[c] = ~out_r[c];   // see (R10) (R12)
               end else if (match[c]) begin
                  unique case (ctrl_r[c][B_ELH:B_ELL])   // see (R03) (R08)
                     ELS_TGL: out_nxt[c] = ~out_r[c];
                     ELS_CLR: out_nxt[c] = 1'b0;
                     ELS_SET: out_nxt[c] = 1'b1;
                     default: out_nxt[c] = out_r[c];
                  endcase
               end
            end
            TCC_CAPTURE, TCC_OFF: begin
               out_nxt[c] = out_r[c];   // see (R10)
            end
         endcase

         irq_nxt[c] = flag_nxt[c] && ctrl_nxt[c][B_IE];   // see (R23)
      end
   end

   // ------------------------------------------------------------
   // Buffered pair selection
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NCH / 2; p++) begin
         last_odd_nxt[p] = last_odd_r[p];
         if (wr && rgn == RGN_VALL && idx == 2'(2 * p)) begin
            last_odd_nxt[p] = 1'b0;
         end else if (wr && rgn == RGN_VALL && idx == 2'(2 * p + 1)) begin
            last_odd_nxt[p] = 1'b1;
         end
         // Swap only at the boundary so no pulse is cut short
         act_odd_nxt[p] = cnt_ovf ? last_odd_r[p] : act_odd_r[p]; // see (R22)
      end
   end

   // ------------------------------------------------------------
   // APB answer: registered, zero wait states
   // ------------------------------------------------------------
   always_comb begin
      pready_nxt  = psel & ~penable;
      pslverr_nxt = psel & ~penable & ~mapped;
      prdata_nxt  = prdata_r;
      if (psel && !penable) begin
         prdata_nxt = '0;
         unique case (rgn)
            RGN_CTRL: begin
               if (!dis[idx]) begin
                  prdata_nxt[B_FLAG:0] = {flag_r[idx], ctrl_r[idx]};
               end
            end
            RGN_VALH: prdata_nxt[BW-1:0] = val_r[idx][VW-1:BW];
            RGN_VALL: prdata_nxt[BW-1:0] = val_r[idx][BW-1:0];
            RGN_STAT: begin
               if (mapped) begin
                  prdata_nxt[2*NCH-1:0] = {oe_r, out_r};
               end
            end
            default:  prdata_nxt = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            ctrl_r[c] <= CTRL_RST;   // see (R05) (R11)
            val_r[c]  <= '0;
         end
         flag_r     <= '0;
         arm_r      <= '0;
         rblk_r     <= '0;
         wblk_r     <= '0;
         out_r      <= '0;
         oe_r       <= '0;
         pin_q_r    <= '0;
         maxe_r     <= '0;
         irq_r      <= '0;
         act_odd_r  <= '0;
         last_odd_r <= '0;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         prdata_r   <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            ctrl_r[c] <= ctrl_nxt[c];
            val_r[c]  <= val_nxt[c];
         end
         flag_r     <= flag_nxt;
         arm_r      <= arm_nxt;
         rblk_r     <= rblk_nxt;
         wblk_r     <= wblk_nxt;
         out_r      <= out_nxt;
         oe_r       <= oe_nxt;
         pin_q_r    <= pin_q_nxt;
         maxe_r     <= maxe_nxt;
         irq_r      <= irq_nxt;
         act_odd_r  <= act_odd_nxt;
         last_odd_r <= last_odd_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
         prdata_r   <= prdata_nxt;
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign ch_pin_out = out_r;
   assign ch_pin_oe  = oe_r;
   assign ch_irq     = irq_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_apb_answer: assert property (
      psel && !penable |=> pready_r ##1 !pready_r)
      else $error("APB answer not one cycle after setup");

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      chk_flag_clear: assert property ($fell(flag_r[g]) |->    // see (R19)
         $past(arm_r[g]) && $past(wr) && !$past(pwdata[B_FLAG]))
         else $error("Flag cleared without read-then-write");
      chk_event_wins: assert property (   // see (R18)
         ev_cap[g] || match[g] |=> flag_r[g])
         else $error("Channel event lost");
      chk_port_release: assert property (   // see (R04) (R06)
         mode[g] == TCC_PORT |=>
         !oe_r[g] && out_r[g] == !$past(ctrl_r[g][B_UNB]))
         else $error("Port mode pin not released");
      chk_compare_drive: assert property (   // see (R03) (R04)
         mode[g] == TCC_COMPARE || mode[g] == TCC_BUFFERED |=> oe_r[g])
         else $error("Compare channel not driving its pin");
      chk_capture_latch: assert property (   // see (R15)
         ev_cap[g] |=> val_r[g] == $past(cnt_value))
         else $error("Capture did not latch count");
      // Rising-only capture must ignore a falling pin
      chk_capture_edge: assert property (   // see (R02) (R07)
         mode[g] == TCC_CAPTURE && !ctrl_r[g][B_ELH] && !wr &&
         pin_q_r[g] && !ch_pin_in[g] |=> $stable(val_r[g]))
         else $error("Capture on an unselected edge");
      chk_capture_block: assert property (   // see (R16)
         rblk_r[g] && !wr |=> $stable(val_r[g]))
         else $error("Capture while high byte held");
      // Outside capture only a match can raise the flag
      chk_compare_block: assert property (   // see (R17)
         wblk_r[g] && mode[g] != TCC_CAPTURE |=> !$rose(flag_r[g]))
         else $error("Match while high byte pending");
      chk_match_action: assert property (   // see (R03) (R08)
         match[g] && !maxe_r[g] && !(ctrl_r[g][B_TOV] && cnt_ovf) |=>
         out_r[g] == ($past(ctrl_r[g][B_ELH:B_ELL]) == ELS_SET ||
                      ($past(ctrl_r[g][B_ELH:B_ELL]) == ELS_TGL &&
                       !$past(out_r[g]))))
         else $error("Compare action not applied");
      chk_ovf_toggle: assert property (   // see (R10) (R12)
         (mode[g] == TCC_COMPARE || mode[g] == TCC_BUFFERED) &&
         ctrl_r[g][B_TOV] && cnt_ovf |=> out_r[g] != $past(out_r[g]))
         else $error("Overflow toggle missing");
      chk_max_force: assert property (   // see (R13)
         mode[g] == TCC_COMPARE && maxe_r[g] && !ctrl_r[g][B_TOV] |=>
         out_r[g] == $past(full_lvl[g]))
         else $error("Max duty level not forced");
      chk_max_latency: assert property (   // see (R14)
         !cnt_ovf |=> $stable(maxe_r[g]))
         else $error("Max duty changed inside period");
      chk_irq_level: assert property (   // see (R23)
         irq_r[g] == (flag_r[g] && ctrl_r[g][B_IE]))
         else $error("Interrupt request mismatch");
   end

   // Only the cycle after a disable is promised; clearing the buffered
   // bit hands the odd channel back at once
   chk_odd_disabled: assert property (   // see (R20)
      dis[1] |=> !oe_r[1])
      else $error("Disabled odd channel still drives");
   chk_odd3_disabled: assert property (   // see (R20)
      dis[3] |=> !oe_r[3])
      else $error("Disabled odd channel still drives");

   // Main scenarios worth seeing at least once
   cov_capture:  cover property (ev_cap[0] ##1 flag_r[0]);
   cov_clear:    cover property ($fell(flag_r[2]));
   cov_buffered: cover property (match[0] && mode[0] == TCC_BUFFERED);
   cov_max:      cover property (maxe_r[2] && mode[2] == TCC_COMPARE);
   cov_ovf_wins: cover property (cnt_ovf && match[2] && ctrl_r[2][B_TOV]);

endmodule : tcc_core

`default_nettype wire

// [include/tcc_pkg.sv]
// Constants, register map and mode decode for the timer channel block.
// Assumes a 16-bit counter outside this block that supplies value and ticks.
package tcc_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NCH = 4;
   localparam int VW  = 16;
   localparam int BW  = 8;

   // ------------------------------------------------------------
   // Register map: word per register, channel index in paddr[3:2]
   // ------------------------------------------------------------
   localparam logic [3:0] RGN_CTRL = 4'h0;
   localparam logic [3:0] RGN_VALH = 4'h1;
   localparam logic [3:0] RGN_VALL = 4'h2;
   localparam logic [3:0] RGN_STAT = 4'h3;
   localparam logic [7:0] ADDR_STAT = 8'h30;

   // ------------------------------------------------------------
   // Channel control bit positions
   // ------------------------------------------------------------
   localparam int B_FLAG = 7;
   localparam int B_IE   = 6;
   localparam int B_BUF  = 5;
   localparam int B_UNB  = 4;
   localparam int B_ELH  = 3;
   localparam int B_ELL  = 2;
   localparam int B_TOV  = 1;
   localparam int B_MAX  = 0;
   localparam logic [6:0] CTRL_RST = 7'h00;

   // ------------------------------------------------------------
   // Edge/level select codes
   // ------------------------------------------------------------
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_TGL = 2'h1;
   localparam logic [1:0] ELS_CLR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;

   typedef enum logic [2:0] {
      TCC_PORT,
      TCC_CAPTURE,
      TCC_COMPARE,
      TCC_BUFFERED,
      TCC_OFF
   } tcc_mode_t;

   // Mode from the control bits; a disabled odd channel is off
   function automatic tcc_mode_t tcc_mode(input logic [6:0] c,
                                          input logic       dis);
      tcc_mode_t m;
      m = TCC_OFF;
      if (dis) begin
         m = TCC_OFF;
      end else if (c[B_ELH:B_ELL] == ELS_OFF) begin
         m = TCC_PORT;
      end else if (c[B_BUF]) begin
         m = TCC_BUFFERED;
      end else if (c[B_UNB]) begin
         m = TCC_COMPARE;
      end else begin
         m = TCC_CAPTURE;
      end
      return m;
   endfunction : tcc_mode

endpackage : tcc_pkg

// [bench/tcc_pin_model.sv]
// Loads and port drivers standing on the four channel pins.
// Assumes the bench moves the port drive levels just after pclk edges.
`timescale 1ns/100ps
`default_nettype none

module tcc_pin_model
   import tcc_pkg::*;
(
   input  wire logic [NCH-1:0] ch_pin_out,
   input  wire logic [NCH-1:0] ch_pin_oe,
   input  wire logic [NCH-1:0] ext_lvl,
   output logic      [NCH-1:0] ch_pin_in
);
   // Port driver owns the pin whenever the timer lets go
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         ch_pin_in[i] = ch_pin_oe[i] ? ch_pin_out[i] : ext_lvl[i];
      end
   end
endmodule : tcc_pin_model

`default_nettype wire

// [bench/test_timer_channel_capture_compare.sv]
// Self-checking bench for the channel block over APB.
// Assumes the bench stands in for the counter, ticking only on demand.
`timescale 1ns/100ps
`default_nettype none

module test_timer_channel_capture_compare;
   import tcc_pkg::*;
   logic           pclk, presetn, psel, penable, pwrite;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, rd, cw;
   logic           pready, pslverr, err, b;
   logic [VW-1:0]  cnt_value, v, val16;
   logic           cnt_tick, cnt_ovf;
   logic [NCH-1:0] ch_pin_in, ch_pin_out, ch_pin_oe, ch_irq, ext_lvl;
   logic [VW-1:0]  expv [NCH];
   logic [7:0]     hi, lo;
   int             failures, checks_done, ch;
   int unsigned    seed;

   tcc_core i_tcc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cnt_value(cnt_value), .cnt_tick(cnt_tick), .cnt_ovf(cnt_ovf),
      .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
      .ch_pin_oe(ch_pin_oe), .ch_irq(ch_irq));
   tcc_pin_model i_tcc_pin_model (.ch_pin_out(ch_pin_out),
      .ch_pin_oe(ch_pin_oe), .ext_lvl(ext_lvl), .ch_pin_in(ch_pin_in));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_of_test();
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Holds the whole request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // High byte first, as software would
   task automatic rdv(input int c);
      logic [7:0] h;
      apb(1'b0, 8'(8'h10 + 4 * c), 32'h0);
      h = rd[7:0];
      apb(1'b0, 8'(8'h20 + 4 * c), 32'h0);
      val16 = {h, rd[7:0]};
   endtask : rdv

   // One counter cycle: tick and/or overflow pulse
   task automatic ev(input logic [15:0] cv, input logic t, input logic o);
      @(posedge pclk);
      cnt_value <= cv;
      cnt_tick  <= t;
      cnt_ovf   <= o;
      @(posedge pclk);
      cnt_tick  <= 1'b0;
      cnt_ovf   <= 1'b0;
   endtask : ev

   task automatic pin(input int c, input logic l, input logic [15:0] cv);
      @(posedge pclk);
      cnt_value  <= cv;
      ext_lvl[c] <= l;
      @(posedge pclk);
   endtask : pin

   // ------------------------------------------------------------
   // Clock, watchdog, sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      #(50 * 20000);
      failures++;
      end_of_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cnt_value = 16'h0;
      cnt_tick = 1'b0;
      cnt_ovf = 1'b0;
      ext_lvl = 4'h0;
      expv = '{default: 16'h0};
      seed = $urandom(32'h4f616247);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
         apb(1'b0, 8'(4 * c), 32'h0);
         chk("ctrl reset", rd, 32'h0);
      end
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("stat reset", rd, 32'h0f);
      apb(1'b1, 8'h00, 32'h10);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("initial low", rd[0], 1'b0);
      apb(1'b1, 8'h00, 32'h20);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("initial high", rd[0], 1'b1);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b0, 8'h34, 32'h0);
      chk("stat alias err", err, 1'b1);
      chk("stat alias data", rd, 32'h0);
      // Every capture code against a rising then a falling edge
      for (int code = 1; code < 4; code++) begin
         ch = $urandom_range(3);
         ext_lvl[ch] <= 1'b0;
         repeat (2) @(posedge pclk);
         cw = 32'(8'h40 | (code << 2));
         apb(1'b1, 8'(4 * ch), cw);
         for (int e = 0; e < 2; e++) begin
            b = (e == 0) ? code[0] : code[1];
            v = 16'($urandom);
            pin(ch, e == 0, v);
            if (b) expv[ch] = v;
            apb(1'b1, 8'(4 * ch), cw);
            apb(1'b0, 8'(4 * ch), 32'h0);
            chk("cap flag", rd[7], b);
            chk("cap irq", ch_irq[ch], b);
            apb(1'b1, 8'(4 * ch), cw);
            apb(1'b0, 8'(4 * ch), 32'h0);
            chk("flag clear", rd[7], 1'b0);
            rdv(ch);
            chk("cap value", val16, expv[ch]);
         end
      end
      // High byte read holds off a capture until the low byte is read
      apb(1'b1, 8'h0c, 32'h0c);
      apb(1'b0, 8'h1c, 32'h0);
      pin(3, 1'b1, 16'h1234);
      apb(1'b0, 8'h0c, 32'h0);
      chk("held flag", rd[7], 1'b0);
      apb(1'b0, 8'h2c, 32'h0);
      pin(3, 1'b0, 16'h4321);
      rdv(3);
      chk("freed value", val16, 16'h4321);
      // Compare actions on channel 2, high write holding off the match
      lo = 8'($urandom);
      apb(1'b1, 8'h28, 32'(lo));
      for (int code = 1; code < 4; code++) begin
         apb(1'b1, 8'h08, 32'(8'h10 | (code << 2)));
         hi = 8'($urandom);
         apb(1'b0, ADDR_STAT, 32'h0);
         b = rd[2];
         apb(1'b1, 8'h18, 32'(hi));
         ev({hi, lo}, 1'b1, 1'b0);
         apb(1'b0, ADDR_STAT, 32'h0);
         chk("match held", rd[2], b);
         chk("cmp drive", rd[6], 1'b1);
         apb(1'b1, 8'h28, 32'(lo));
         ev({hi, lo}, 1'b1, 1'b0);
         apb(1'b0, ADDR_STAT, 32'h0);
         chk("cmp action", rd[2], code == 1 ? !b : code == 3);
      end
      // Pin is now high from set-on-compare
      apb(1'b1, 8'h08, 32'h1e);
      ev({hi, lo}, 1'b1, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("ovf wins", rd[2], 1'b0);
      ev(16'h0, 1'b0, 1'b1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("ovf toggle", rd[2], 1'b1);
      // Full duty for set-on-compare holds the pin low
      apb(1'b1, 8'h08, 32'h1d);
      ev(16'h0, 1'b0, 1'b1);
      ev({hi, lo}, 1'b1, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("max duty", rd[2], 1'b0);
      apb(1'b1, 8'h08, 32'h1c);
      ev({hi, lo}, 1'b1, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("max lingers", rd[2], 1'b0);
      ev(16'h0, 1'b0, 1'b1);
      ev({hi, lo}, 1'b1, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("max gone", rd[2], 1'b1);
      chk("pin out", ch_pin_out[2], 1'b1);
      // Buffered channel 0, clear on compare, shuts out channel 1
      apb(1'b1, 8'h00, 32'h28);
      apb(1'b1, 8'h04, 32'h14);
      apb(1'b0, 8'h04, 32'h0);
      chk("odd ctrl", rd, 32'h0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("odd released", rd[5:4], 2'b01);
      // Last low write went to the odd member: it is used after overflow
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h24, 32'(lo));
      ev(16'h0, 1'b0, 1'b1);
      ev({8'h00, lo}, 1'b1, 1'b0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("buffered clear", rd[0], 1'b0);
      chk("pin oe", ch_pin_oe, 4'h5);
      end_of_test();
   end
endmodule : test_timer_channel_capture_compare

`default_nettype wire
